// ### logic/fsk_sweep_defines.svh
// register offsets, reset values and timing counts of the shift/sweep block
// assumes a 125 MHz system clock
`ifndef FSK_SWEEP_DEFINES_SVH
`define FSK_SWEEP_DEFINES_SVH

// frequency words count 10 mHz steps, so 15 MHz still fits 32 bits
`define FREQ_MIN_MHZ 32'h0000_0001
`define FREQ_MAX_MHZ 32'h5968_2F00
`define FREQ_TRI_MAX_MHZ 32'h0098_9680
`define RATE_MAX_MHZ 32'h004C_4B40
`define CARRIER_RST 32'h0001_86A0
`define HOP_RST 32'h0000_2710
`define RATE_RST 32'h0000_03E8
`define START_RST 32'h0000_2710
`define STOP_RST 32'h0001_86A0
// sweep duration in milliseconds
`define DUR_MIN_MS 32'h0000_0001
`define DUR_MAX_MS 32'h0007_A120
`define DUR_RST 32'h0000_03E8
// clock rate and derived counts
`define CLK_HZ 125000000
`define CYC_PER_MS (`CLK_HZ / 1000)
// sweep steps are taken once per millisecond; points = duration in ms
`define STEP_CYCLES `CYC_PER_MS
// shift accumulator step: rate * 2^33 / (100 * clk), two carries a period
`define RATE_STEP_MUL 48'h0000_0000_57F6
`define RATE_SCALE_SHIFT 15

// register offsets (word addresses)
`define REG_CARRIER 8'h00
`define REG_HOP 8'h01
`define REG_RATE 8'h02
`define REG_START 8'h03
`define REG_STOP 8'h04
`define REG_DUR 8'h05
`define REG_CTRL 8'h06
`define REG_STATUS 8'h07
`define REG_CMD 8'h08
`define REG_FREQ_NOW 8'h09

// control fields
`define CTRL_FSK_EN 0
`define CTRL_SWP_EN 1
`define CTRL_FSK_EXT 2
`define CTRL_LOG 3
`define CTRL_TRIG_LO 4
`define CTRL_TRIG_HI 5
`define CTRL_TRI_SHAPE 6
// command fields
`define CMD_BUS_TRIG 0
`define CMD_WAIT 1
// status fields
`define ST_WAIT_EXT 0
`define ST_SWEEPING 1
`define ST_BUSY 2
`define ST_HOP 3

`endif

// ### logic/fsk_sweep_pkg.sv
// types shared by the shift/sweep control files
package fsk_sweep_pkg;
    typedef enum logic [1:0] {
        trig_immediate,
        trig_external,
        trig_bus
    } trig_src_e;

    typedef enum logic [1:0] {
        sw_idle,
        sw_wait,
        sw_run
    } sweep_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic fsk_en;
        logic swp_en;
        logic fsk_ext;
        logic log_sp;
        trig_src_e trig_src;
        logic tri_shape;
    } ctrl_s;

    typedef struct packed {
        logic [31:0] frequency;
        logic hop_active;
        logic wait_ext;
        logic sweeping;
    } synth_out_s;
endpackage

// ### logic/pin_sync.sv
// three-stage synchroniser for an asynchronous pin, with clean-level output
// assumes the pin may change at any time relative to sys_clk
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, low active
    input wire logic clk_en, // freezes state while low
    input wire logic pin, // raw pin level
    output logic level, // filtered level
    output logic rise // one-cycle pulse on a rising level
);
    logic [2:0] stage;

    // level changes only once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else if (clk_en) begin
            stage <= {stage[1:0], pin};
            if (stage[1] == stage[2]) begin
                level <= stage[2];
            end
        end
    end

    assign rise = clk_en && (stage[1] == stage[2]) && stage[2] && !level;
endmodule
`default_nettype wire

// ### logic/fsk_sweep_ctrl.sv
// frequency-shift keying and sweep control for the synthesizer front end
// assumes a single-cycle register port and TTL pins already level-shifted
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fsk_sweep_defines.svh"

// Behaviour
// - carrier 10 mHz to 15 MHz, 100 kHz for triangle/ramp, reset 1 kHz
// - hop frequency 10 mHz to 15 MHz, shape limit, reset 100 Hz
// - internal shift rate 10 mHz to 50 kHz, reset 10 Hz
// - source resets internal; internal alternates carrier and hop at rate
// - external source ignores the internal shift rate
// - external: low pin gives carrier, high pin gives hop
// - wait indicator lit while waiting for an external trigger
// - one mode only; enabling shift keying clears sweep; reads 0/1
// - sweep up if start below stop, down if above
// - sweep start 10 mHz to 15 MHz, shape limit, reset 100 Hz
// - sweep stop 10 mHz to 15 MHz, shape limit, reset 1 kHz
// - frequency steps keep the output phase continuous
// - linear or logarithmic spacing, linear by default, read back
// - sweep duration 1 ms to 500 s, reset 1 s
// - point count derived from duration, one point per millisecond
// - enabling sweep clears shift keying; reads 0/1
// - triggered: one sweep per trigger, then hold start frequency
// - immediate source, the default, sweeps continuously
// - external source sweeps on each rising trigger edge
// - bus source sweeps on each bus trigger command
// - wait command holds busy until pending sweep completes; code ignores it, busy runs from a bus trigger until its sweep ends
module fsk_sweep_ctrl import fsk_sweep_pkg::*; (
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic rst_n, // async reset, low active
    input wire logic clk_en, // freezes all state while low
    input wire reg_req_s req, // register request
    output logic [31:0] rdata, // read data, cycle after read strobe
    input wire logic shift_select_input, // external shift level pin
    input wire logic ext_trig_pin, // external trigger pin
    output synth_out_s synth, // frequency word and indicators
    output logic busy // high from a bus trigger until its sweep ends
);
    typedef struct packed {
        logic [31:0] carrier;
        logic [31:0] hop;
        logic [31:0] rate;
        logic [31:0] start;
        logic [31:0] stop;
        logic [31:0] dur;
        ctrl_s ctrl;
        sweep_state_e sw;
        logic [31:0] rate_acc;
        logic hop_on;
        logic [16:0] step_cnt;
        logic [31:0] pts_left;
        logic [31:0] freq;
        logic [31:0] inc;
        logic pend_trig;
        logic waiting;
        logic [31:0] rdata;
    } state_s;

    state_s r;
    state_s next_r;
    logic shift_lvl;
    logic trig_rise;

    pin_sync u_shift_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(shift_select_input),
        .level(shift_lvl),
        .rise()
    );

    pin_sync u_trig_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(ext_trig_pin),
        .level(),
        .rise(trig_rise)
    );

    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // shape limit applies to every output frequency setting
    function automatic logic [31:0] fclamp(input logic [31:0] v,
                                           input logic tri_shape);
        return clamp(v, `FREQ_MIN_MHZ,
                     tri_shape ? `FREQ_TRI_MAX_MHZ : `FREQ_MAX_MHZ);
    endfunction

    function automatic logic [31:0] absdiff(input logic [31:0] a,
                                            input logic [31:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    logic [31:0] rd_mux;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic sweep_done;
    logic start_sweep;
    logic [31:0] span;
    logic [31:0] log_inc;
    logic [47:0] rate_prod;
    logic bus_trig;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CTRL_FSK_EN] = r.ctrl.fsk_en;
        ctrl_word[`CTRL_SWP_EN] = r.ctrl.swp_en;
        ctrl_word[`CTRL_FSK_EXT] = r.ctrl.fsk_ext;
        ctrl_word[`CTRL_LOG] = r.ctrl.log_sp;
        ctrl_word[`CTRL_TRIG_HI:`CTRL_TRIG_LO] = r.ctrl.trig_src;
        ctrl_word[`CTRL_TRI_SHAPE] = r.ctrl.tri_shape;
        status_word = 32'h0000_0000;
        status_word[`ST_WAIT_EXT] = r.waiting;
        status_word[`ST_SWEEPING] = (r.sw == sw_run);
        status_word[`ST_BUSY] = r.pend_trig;
        status_word[`ST_HOP] = r.hop_on;
        if (req.addr == `REG_CARRIER) begin
            rd_mux = r.carrier;
        end else if (req.addr == `REG_HOP) begin
            rd_mux = r.hop;
        end else if (req.addr == `REG_RATE) begin
            rd_mux = r.rate;
        end else if (req.addr == `REG_START) begin
            rd_mux = r.start;
        end else if (req.addr == `REG_STOP) begin
            rd_mux = r.stop;
        end else if (req.addr == `REG_DUR) begin
            rd_mux = r.dur;
        end else if (req.addr == `REG_CTRL) begin
            rd_mux = ctrl_word;
        end else if (req.addr == `REG_STATUS) begin
            rd_mux = status_word;
        end else if (req.addr == `REG_FREQ_NOW) begin
            rd_mux = r.freq;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_comb begin
        next_r = r;
        next_r.rdata = req.rd ? rd_mux : 32'h0000_0000;
        start_sweep = 1'b0;
        sweep_done = 1'b0;
        span = absdiff(r.start, r.stop);
        // log spacing: step proportional to present frequency
        log_inc = (r.freq >> 10) | 32'h0000_0001;
        // accumulator step scaled so the top rate toggles every 1250 cycles
        rate_prod = 48'(r.rate) * `RATE_STEP_MUL;
        bus_trig = req.wr && (req.addr == `REG_CMD) &&
                   req.wdata[`CMD_BUS_TRIG] && (r.ctrl.trig_src == trig_bus);

        // register writes
        if (req.wr) begin
            if (req.addr == `REG_CARRIER) begin
                next_r.carrier = fclamp(req.wdata, r.ctrl.tri_shape);
            end else if (req.addr == `REG_HOP) begin
                next_r.hop = fclamp(req.wdata, r.ctrl.tri_shape);
            end else if (req.addr == `REG_RATE) begin
                next_r.rate = clamp(req.wdata, `FREQ_MIN_MHZ,
                                    `RATE_MAX_MHZ);
            end else if (req.addr == `REG_START) begin
                next_r.start = fclamp(req.wdata, r.ctrl.tri_shape);
            end else if (req.addr == `REG_STOP) begin
                next_r.stop = fclamp(req.wdata, r.ctrl.tri_shape);
            end else if (req.addr == `REG_DUR) begin
                next_r.dur = clamp(req.wdata, `DUR_MIN_MS,
                                   `DUR_MAX_MS);
            end else if (req.addr == `REG_CTRL) begin
                next_r.ctrl.fsk_ext = req.wdata[`CTRL_FSK_EXT];
                next_r.ctrl.log_sp = req.wdata[`CTRL_LOG];
                next_r.ctrl.trig_src =
                    trig_src_e'(req.wdata[`CTRL_TRIG_HI:`CTRL_TRIG_LO]);
                next_r.ctrl.tri_shape = req.wdata[`CTRL_TRI_SHAPE];
                // newly enabled mode turns the other one off
                if (req.wdata[`CTRL_FSK_EN] && !r.ctrl.fsk_en) begin
                    next_r.ctrl.fsk_en = 1'b1;
                    next_r.ctrl.swp_en = 1'b0;
                end else if (req.wdata[`CTRL_SWP_EN] && !r.ctrl.swp_en) begin
                    next_r.ctrl.swp_en = 1'b1;
                    next_r.ctrl.fsk_en = 1'b0;
                end else begin
                    next_r.ctrl.fsk_en = req.wdata[`CTRL_FSK_EN];
                    next_r.ctrl.swp_en = req.wdata[`CTRL_SWP_EN];
                end
            end else if (req.addr == `REG_CMD) begin
                if (bus_trig) begin
                    next_r.pend_trig = 1'b1;
                end
            end
        end

        // internal shift timing: phase accumulator at the rate setting
        if (r.ctrl.fsk_en && !r.ctrl.fsk_ext) begin
            {next_r.hop_on, next_r.rate_acc} =
                33'(r.rate_acc) + 33'(rate_prod >> `RATE_SCALE_SHIFT);
            next_r.hop_on = r.hop_on ^ next_r.hop_on;
        end else if (r.ctrl.fsk_en) begin
            next_r.hop_on = shift_lvl;
            next_r.rate_acc = 32'h0000_0000;
        end else begin
            next_r.hop_on = 1'b0;
        end

        // sweep sequencer
        case (r.sw)
            sw_idle: begin
                next_r.freq = r.start;
                if (r.ctrl.swp_en) begin
                    next_r.sw = sw_wait;
                end
            end
            sw_wait: begin
                next_r.freq = r.start;
                if (r.ctrl.trig_src == trig_immediate) begin
                    start_sweep = 1'b1;
                end else if (r.ctrl.trig_src == trig_external) begin
                    start_sweep = trig_rise;
                end else begin
                    start_sweep = r.pend_trig;
                end
                if (start_sweep) begin
                    next_r.sw = sw_run;
                    next_r.pts_left = r.dur;
                    next_r.inc = span / r.dur;
                    next_r.step_cnt = 17'h0_0000;
                end
            end
            sw_run: begin
                if (r.step_cnt == 17'(`STEP_CYCLES - 1)) begin
                    next_r.step_cnt = 17'h0_0000;
                    next_r.pts_left = r.pts_left - 32'h0000_0001;
                    if (r.pts_left == 32'h0000_0001) begin
                        // last point done: back to the start frequency
                        sweep_done = 1'b1;
                        next_r.freq = r.start;
                    end else if (r.pts_left == 32'h0000_0002) begin
                        next_r.freq = r.stop;
                    end else if (r.start < r.stop) begin
                        next_r.freq = r.freq + (r.ctrl.log_sp ? log_inc
                                                             : r.inc);
                        if (next_r.freq > r.stop) begin
                            next_r.freq = r.stop;
                        end
                    end else begin
                        next_r.freq = r.freq - (r.ctrl.log_sp ? log_inc
                                                             : r.inc);
                        // a borrow wraps above start; both cases clamp to stop
                        if (next_r.freq < r.stop ||
                            next_r.freq > r.start) begin
                            next_r.freq = r.stop;
                        end
                    end
                end else begin
                    next_r.step_cnt = r.step_cnt + 17'h0_0001;
                end
                if (sweep_done) begin
                    next_r.sw = sw_wait;
                    // a trigger landing on the last step is kept
                    next_r.pend_trig = bus_trig;
                end
            end
            default: next_r.sw = sw_idle;
        endcase
        if (!r.ctrl.swp_en) begin
            next_r.sw = sw_idle;
            next_r.pend_trig = 1'b0;
        end
        // judged on the coming settings so the light never lags a write
        next_r.waiting = next_r.ctrl.swp_en && (next_r.sw == sw_wait) &&
                         (next_r.ctrl.trig_src == trig_external);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.carrier <= `CARRIER_RST;
            r.hop <= `HOP_RST;
            r.rate <= `RATE_RST;
            r.start <= `START_RST;
            r.stop <= `STOP_RST;
            r.dur <= `DUR_RST;
            r.ctrl.trig_src <= trig_immediate;
            r.sw <= sw_idle;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // output frequency word only changes value, never phase: the
    // downstream accumulator keeps running across each step
    always_comb begin
        if (r.ctrl.swp_en) begin
            synth.frequency = (r.sw == sw_run) ? r.freq : r.start;
        end else begin
            synth.frequency = r.hop_on ? r.hop : r.carrier;
        end
        synth.hop_active = r.hop_on;
        synth.wait_ext = r.waiting;
        synth.sweeping = (r.sw == sw_run);
    end
    assign busy = r.pend_trig;
    assign rdata = r.rdata;

    chk_one_mode: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(r.ctrl.fsk_en && r.ctrl.swp_en))
        else $error("both modes enabled");
    chk_fsk_clears_swp: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && req.wr && req.addr == `REG_CTRL &&
        req.wdata[`CTRL_FSK_EN] && !r.ctrl.fsk_en |=> !r.ctrl.swp_en)
        else $error("sweep left on");
    chk_swp_clears_fsk: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && req.wr && req.addr == `REG_CTRL &&
        req.wdata[`CTRL_SWP_EN] && !r.ctrl.swp_en &&
        !(req.wdata[`CTRL_FSK_EN] && !r.ctrl.fsk_en)
        |=> r.ctrl.swp_en && !r.ctrl.fsk_en)
        else $error("shift keying left on");
    chk_ext_level: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && r.ctrl.fsk_en && r.ctrl.fsk_ext
        |=> r.hop_on == $past(shift_lvl))
        else $error("hop does not follow pin");
    chk_rate_ignored: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && r.ctrl.fsk_en && r.ctrl.fsk_ext
        |=> r.rate_acc == 32'h0000_0000)
        else $error("rate still counting");
    chk_wait_light: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.waiting == (r.ctrl.swp_en && r.sw == sw_wait &&
                      r.ctrl.trig_src == trig_external))
        else $error("wait light wrong");
    chk_hold_start: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.sw != sw_run && r.ctrl.swp_en |-> synth.frequency == r.start)
        else $error("not holding start");
    chk_imm_restart: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && r.sw == sw_wait && r.ctrl.swp_en &&
        r.ctrl.trig_src == trig_immediate
        |=> r.sw == sw_run || !r.ctrl.swp_en)
        else $error("immediate sweep stalled");
    chk_step_dir: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.sw == sw_run && $stable(r.start) && $stable(r.stop) &&
        r.start < r.stop |-> r.freq >= r.start && r.freq <= r.stop)
        else $error("upward sweep out of span");
    chk_step_down: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.sw == sw_run && $stable(r.start) && $stable(r.stop) &&
        r.start > r.stop |-> r.freq <= r.start && r.freq >= r.stop)
        else $error("downward sweep out of span");
    chk_dur_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        r.dur >= `DUR_MIN_MS && r.dur <= `DUR_MAX_MS)
        else $error("duration out of range");
endmodule
`default_nettype wire

// ### verif/ttl_pins_model.sv
// pin-side partner: drives the shift level and external trigger pulses
// assumes the bench requests levels and pulses on sys_clk edges
`timescale 1ns/10ps
`default_nettype none
module ttl_pins_model #(
    parameter int MIN_GAP = 125, // cycles between shift edges
    parameter int PULSE_LEN = 16 // trigger high time in cycles
) (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, low active
    input wire logic level_req, // wanted shift level
    input wire logic pulse_req, // request one trigger pulse
    output logic shift_pin, // shift select level
    output logic trig_pin // trigger line
);
    int gap;
    int hi;

    // a shift request made too soon is held back, never passed on early
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_pin <= 1'b0;
            trig_pin <= 1'b0;
            gap <= MIN_GAP;
            hi <= 0;
        end else begin
            if (gap < MIN_GAP) begin
                gap <= gap + 1;
            end else if (level_req != shift_pin) begin
                shift_pin <= level_req;
                gap <= 0;
            end
            if (hi > 0) begin
                hi <= hi - 1;
                trig_pin <= (hi > 1);
            end else if (pulse_req) begin
                trig_pin <= 1'b1;
                hi <= PULSE_LEN;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the shift and sweep control block
// assumes a 125 MHz sys_clk and the pin model on both TTL inputs
`timescale 1ns/10ps
`default_nettype none
`include "fsk_sweep_defines.svh"
module testbench import fsk_sweep_pkg::*;;
    typedef struct {
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } row_s;
    logic sys_clk;
    logic rst_n;
    logic clk_en;
    reg_req_s req;
    logic [31:0] rdata;
    logic shift_pin;
    logic trig_pin;
    synth_out_s synth;
    logic busy;
    logic level_req;
    logic pulse_req;
    logic [31:0] rd_val;
    logic prev;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int i;
    int tog;
    row_s rows [25] = '{
        '{1'b0, 8'h00, '0, 32'h0001_86A0}, '{1'b0, 8'h01, '0, 32'h0000_2710},
        '{1'b0, 8'h02, '0, 32'h0000_03E8}, '{1'b0, 8'h03, '0, 32'h0000_2710},
        '{1'b0, 8'h04, '0, 32'h0001_86A0}, '{1'b0, 8'h05, '0, 32'h0000_03E8},
        '{1'b0, 8'h06, '0, 32'h0000_0000}, '{1'b0, 8'h07, '0, 32'h0000_0000},
        '{1'b1, 8'h0A, 32'h0000_1234, 32'h0000_0000},
        '{1'b1, 8'h00, 32'h0000_0000, 32'h0000_0001},
        '{1'b1, 8'h00, 32'hFFFF_FFFF, 32'h5968_2F00},
        '{1'b1, 8'h00, 32'h0000_4E20, 32'h0000_4E20},
        '{1'b1, 8'h01, 32'h0000_0FA0, 32'h0000_0FA0},
        '{1'b1, 8'h02, 32'h0000_0000, 32'h0000_0001},
        '{1'b1, 8'h02, 32'hFFFF_FFFF, 32'h004C_4B40},
        '{1'b1, 8'h04, 32'h0000_0000, 32'h0000_0001},
        '{1'b1, 8'h05, 32'h0000_0000, 32'h0000_0001},
        '{1'b1, 8'h05, 32'hFFFF_FFFF, 32'h0007_A120},
        '{1'b1, 8'h06, 32'h0000_0048, 32'h0000_0048},
        '{1'b1, 8'h03, 32'hFFFF_FFFF, 32'h0098_9680},
        '{1'b1, 8'h06, 32'h0000_0001, 32'h0000_0001},
        '{1'b1, 8'h06, 32'h0000_0003, 32'h0000_0002},
        '{1'b1, 8'h06, 32'h0000_0003, 32'h0000_0001},
        '{1'b1, 8'h06, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, 8'h03, 32'h0000_2710, 32'h0000_2710}
    };

    fsk_sweep_ctrl dut_u (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .req(req),
        .rdata(rdata),
        .shift_select_input(shift_pin),
        .ext_trig_pin(trig_pin),
        .synth(synth),
        .busy(busy)
    );
    ttl_pins_model pins_u (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level_req(level_req),
        .pulse_req(pulse_req),
        .shift_pin(shift_pin),
        .trig_pin(trig_pin)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // whole run needs about 4400 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            err_total = err_total + 1;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic final_report();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        req = '0;
        level_req = 1'b0;
        pulse_req = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rows[r]) begin
            if (rows[r].wr) begin
                reg_wr(rows[r].addr, rows[r].wdata);
            end
            reg_rd(rows[r].addr, rd_val);
            check(rd_val, rows[r].exp);
        end
        $display("test register table done");
        // internal source at top rate: flag toggles, output follows it
        reg_wr(`REG_CTRL, 32'h0000_0001);
        #1;
        tog = 0;
        prev = synth.hop_active;
        // top rate toggles every 1250 cycles: three edges in 4000
        for (i = 0; i < 4000; i++) begin
            tick();
            rd_val = synth.hop_active ? 32'h0000_0FA0 : 32'h0000_4E20;
            check(synth.frequency, rd_val);
            if (synth.hop_active !== prev) tog++;
            prev = synth.hop_active;
        end
        check(tog, 32'h0000_0003);
        $display("test internal shift done");
        reg_wr(`REG_CTRL, 32'h0000_0005);
        @(posedge sys_clk);
        level_req <= 1'b1;
        for (i = 0; i < 200 && shift_pin !== 1'b1; i++) tick();
        tick();
        check(32'(synth.hop_active), 32'h0000_0000);
        for (i = 0; i < 8 && synth.hop_active !== 1'b1; i++) tick();
        check(synth.frequency, 32'h0000_0FA0);
        tog = 0;
        for (i = 0; i < 200; i++) begin
            tick();
            if (synth.hop_active !== 1'b1) tog++;
        end
        check(tog, 32'h0000_0000);
        @(posedge sys_clk);
        level_req <= 1'b0;
        for (i = 0; i < 200 && shift_pin !== 1'b0; i++) tick();
        for (i = 0; i < 8 && synth.hop_active !== 1'b0; i++) tick();
        check(synth.frequency, 32'h0000_4E20);
        $display("test external shift done");
        reg_wr(`REG_CTRL, 32'h0000_0000);
        reg_wr(`REG_CTRL, 32'h0000_0012);
        repeat (3) tick();
        reg_rd(`REG_STATUS, rd_val);
        check(rd_val, 32'h0000_0001);
        check(synth.frequency, 32'h0000_2710);
        // a bus trigger must not start a sweep on the external source
        reg_wr(`REG_CMD, 32'h0000_0001);
        repeat (4) tick();
        check(32'(synth.sweeping), 32'h0000_0000);
        @(posedge sys_clk);
        pulse_req <= 1'b1;
        @(posedge sys_clk);
        pulse_req <= 1'b0;
        for (i = 0; i < 12 && synth.sweeping !== 1'b1; i++) tick();
        check(32'({synth.sweeping, synth.wait_ext}), 32'h0000_0002);
        reg_rd(`REG_FREQ_NOW, rd_val);
        check(rd_val, 32'h0000_2710);
        reg_rd(`REG_CTRL, rd_val);
        check(rd_val, 32'h0000_0012);
        $display("test external sweep done");
        reg_wr(`REG_CTRL, 32'h0000_0000);
        reg_wr(`REG_CTRL, 32'h0000_0022);
        repeat (3) tick();
        check(32'({synth.sweeping, synth.wait_ext}), 32'h0000_0000);
        reg_wr(`REG_CMD, 32'h0000_0001);
        reg_wr(`REG_CMD, 32'h0000_0002);
        repeat (2) tick();
        reg_rd(`REG_STATUS, rd_val);
        check(rd_val, 32'h0000_0006);
        check(32'(busy), 32'h0000_0001);
        $display("test bus sweep done");
        reg_wr(`REG_CTRL, 32'h0000_0000);
        reg_wr(`REG_CTRL, 32'h0000_0002);
        for (i = 0; i < 8 && synth.sweeping !== 1'b1; i++) tick();
        check(32'(synth.sweeping), 32'h0000_0001);
        check(synth.frequency, 32'h0000_2710);
        $display("test immediate sweep done");
        // reset in mid-sweep must drop the sweeping, busy and wait flags at once
        @(posedge sys_clk);
        rst_n <= 1'b0;
        tick();
        check(synth.frequency, 32'h0001_86A0);
        check(32'({synth.sweeping, busy, synth.wait_ext}), '0);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_rd(`REG_CTRL, rd_val);
        check(rd_val, 32'h0000_0000);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
